// >>> sie_irq_enable.sv
// Purpose: Interrupt enable and request steering for the serial port unit
// Assumes: Flag inputs come from logic on clk_sys; bus master follows one-cycle strobes
// Notes:   All outputs are registered, so each answer lags its cause by one edge
`timescale 1ns/1ns
`include "sie_regs.svh"

// How it works
// - Sixteen-bit enable register, read and write.
// - Enabled bit with set flag raises interrupt.
// - Bit 15 steers transmit source to DMA.
// - Transmit data request is the steered source.
// - Bit 14 gates transmit control ready.
// - Bit 13 gates transmit FIFO empty.
// - Bit 12 gates transmit data request.
// - Bit 11 steers receive source to DMA.
// - Receive data request is the steered source.
// - Bit 10 gates receive control ready.
// - Bit 9 gates receive FIFO full.
// - Bit 8 gates receive data request.
// - Bits 7 and 6 read zero.
// - Bit 5 gates slot assign error.
// - Bit 4 gates frame sync error.
// - Bit 3 gates transmit FIFO overflow.
// - Bit 2 gates transmit FIFO underflow.
// - Bit 1 gates receive FIFO underflow.
// - Bit 0 gates receive FIFO overflow.
// - Error flags clear on writing one.
module sie_irq_enable
(
    input  wire logic                   clk_sys,     // System clock, 250 MHz
    input  wire logic                   reset,       // Asynchronous reset, active high
    input  wire sie_pkg::sie_bus_req_t  bus,         // Register port request
    output logic [`SIE_DATA_W-1:0]      rd_data,     // Read data, cycle after read strobe
    input  wire sie_pkg::sie_level_t    level_flags, // Level status from engine
    input  wire sie_pkg::sie_err_t      err_evt,     // Error event pulses from engine
    output logic                        irq_out,     // Port interrupt to CPU, level
    output logic                        tx_dma_req,  // Transmit transfer request to DMA
    output logic                        rx_dma_req   // Receive transfer request to DMA
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [`SIE_DATA_W-1:0] ier_reg;
    logic [`SIE_DATA_W-1:0] ier_next;
    logic [`SIE_ERR_W-1:0]  err_reg;
    logic [`SIE_ERR_W-1:0]  err_next;
    logic [`SIE_DATA_W-1:0] rd_data_reg;
    logic [`SIE_DATA_W-1:0] rd_data_next;
    logic                   irq_reg;
    logic                   irq_next;
    logic                   tx_dma_reg;
    logic                   tx_dma_next;
    logic                   rx_dma_reg;
    logic                   rx_dma_next;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    wire logic sel_ier;
    wire logic sel_stat;
    wire logic wr_ier;
    wire logic wr_stat;
    wire logic rd_ier;
    wire logic rd_stat;

    assign sel_ier  = (bus.addr == `SIE_OFF_IER);
    assign sel_stat = (bus.addr == `SIE_OFF_STAT);
    assign wr_ier   = bus.wr & sel_ier;
    assign wr_stat  = bus.wr & sel_stat;
    assign rd_ier   = bus.rd & sel_ier;
    assign rd_stat  = bus.rd & sel_stat;

    // ------------------------------------------------------------------
    // Enable register
    // ------------------------------------------------------------------
    // Reserved bits never stored, so they read back as zero
    assign ier_next = wr_ier ? (bus.wdata & `SIE_IER_WMASK) : ier_reg;

    // ------------------------------------------------------------------
    // Sticky error flags
    // ------------------------------------------------------------------
    wire logic [`SIE_ERR_W-1:0] err_evt_vec;
    wire logic [`SIE_ERR_W-1:0] err_clr_vec;

    assign err_evt_vec = err_evt;
    assign err_clr_vec = wr_stat ? bus.wdata[`SIE_B_ERR_HI:`SIE_B_ERR_LO] : `SIE_ERR_RESET;

    genvar gi;
    generate
        for (gi = 0; gi < `SIE_ERR_W; gi++)
        begin : g_err
            // Event in the clearing cycle wins over the clear
            assign err_next[gi] = err_evt_vec[gi] | (err_reg[gi] & ~err_clr_vec[gi]);
        end
    endgenerate

    // ------------------------------------------------------------------
    // Status view, laid out like the enable register
    // ------------------------------------------------------------------
    wire logic [`SIE_DATA_W-1:0] stat_vec;

    assign stat_vec = {1'h0,
                       level_flags.tx_ctrl_ready,
                       level_flags.tx_fifo_empty,
                       level_flags.tx_data_req,
                       1'h0,
                       level_flags.rx_ctrl_ready,
                       level_flags.rx_fifo_full,
                       level_flags.rx_data_req,
                       2'h0,
                       err_reg};

    // ------------------------------------------------------------------
    // Gating and steering
    // ------------------------------------------------------------------
    wire logic [`SIE_DATA_W-1:0] gated_vec;
    wire logic                   tx_to_dma;
    wire logic                   rx_to_dma;
    wire logic [`SIE_DATA_W-1:0] cpu_route_mask;
    wire logic [`SIE_DATA_W-1:0] cpu_vec;

    // Steering bits are not sources themselves
    assign gated_vec = ier_reg & stat_vec;
    assign tx_to_dma = ier_reg[`SIE_B_TX_DMA_SEL];
    assign rx_to_dma = ier_reg[`SIE_B_RX_DMA_SEL];

    // Drop the data request sources that are steered to DMA
    assign cpu_route_mask = `SIE_IER_WMASK
                            & ~(16'(tx_to_dma) << `SIE_B_TX_DATA_REQ)
                            & ~(16'(rx_to_dma) << `SIE_B_RX_DATA_REQ);
    assign cpu_vec = gated_vec & cpu_route_mask;

    assign irq_next    = |cpu_vec;
    assign tx_dma_next = tx_to_dma & gated_vec[`SIE_B_TX_DATA_REQ];
    assign rx_dma_next = rx_to_dma & gated_vec[`SIE_B_RX_DATA_REQ];

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    wire logic [`SIE_DATA_W-1:0] rd_mux;

    // Unmapped addresses read as zero; data stand one cycle only
    assign rd_mux = rd_ier  ? ier_reg :
                    rd_stat ? stat_vec :
                              `SIE_DATA_ZERO;
    assign rd_data_next = rd_mux;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            ier_reg <= `SIE_IER_RESET;
        else
            ier_reg <= ier_next;
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            err_reg <= `SIE_ERR_RESET;
        else
            err_reg <= err_next;
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            rd_data_reg <= `SIE_DATA_ZERO;
        else
            rd_data_reg <= rd_data_next;
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            irq_reg <= 1'h0;
        else
            irq_reg <= irq_next;
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            tx_dma_reg <= 1'h0;
        else
            tx_dma_reg <= tx_dma_next;
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            rx_dma_reg <= 1'h0;
        else
            rx_dma_reg <= rx_dma_next;
    end

    assign rd_data    = rd_data_reg;
    assign irq_out    = irq_reg;
    assign tx_dma_req = tx_dma_reg;
    assign rx_dma_req = rx_dma_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb_sys @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    wire logic only_tx_req;
    wire logic only_rx_req;
    wire logic any_enabled_flag;

    assign only_tx_req      = (stat_vec == (16'h0001 << `SIE_B_TX_DATA_REQ));
    assign only_rx_req      = (stat_vec == (16'h0001 << `SIE_B_RX_DATA_REQ));
    assign any_enabled_flag = |(ier_reg & stat_vec & `SIE_IER_WMASK);

    a_ier_write_readback: assert property (
        (rd_ier && $past(wr_ier))
        |=> (rd_data == ($past(bus.wdata, 2) & `SIE_IER_WMASK)))
        else $error("Enable register read does not return written value");

    a_rsvd_read_zero: assert property (
        rd_ier |=> (rd_data[`SIE_B_RSVD_HI:`SIE_B_RSVD_LO] == 2'h0))
        else $error("Reserved enable bits read nonzero");

    a_irq_no_cause: assert property (
        !any_enabled_flag |=> !irq_out)
        else $error("Interrupt raised with no enabled flag");

    a_err_gate_irq: assert property (
        (|(ier_reg[`SIE_B_ERR_HI:`SIE_B_ERR_LO] & err_reg)) |=> irq_out)
        else $error("Enabled error flag did not raise interrupt");

    a_level_gate_irq: assert property (
        ((ier_reg[`SIE_B_TX_CTRL_RDY] && level_flags.tx_ctrl_ready)
         || (ier_reg[`SIE_B_TX_FIFO_EMPTY] && level_flags.tx_fifo_empty)
         || (ier_reg[`SIE_B_RX_CTRL_RDY] && level_flags.rx_ctrl_ready)
         || (ier_reg[`SIE_B_RX_FIFO_FULL] && level_flags.rx_fifo_full))
        |=> irq_out)
        else $error("Enabled level flag did not raise interrupt");

    a_tx_dma_route: assert property (
        (only_tx_req && ier_reg[`SIE_B_TX_DATA_REQ] && ier_reg[`SIE_B_TX_DMA_SEL])
        |=> (tx_dma_req && !irq_out))
        else $error("Transmit request not steered to DMA alone");

    a_tx_cpu_route: assert property (
        (level_flags.tx_data_req && ier_reg[`SIE_B_TX_DATA_REQ] && !ier_reg[`SIE_B_TX_DMA_SEL])
        |=> (irq_out && !tx_dma_req))
        else $error("Transmit request not steered to CPU");

    a_rx_dma_route: assert property (
        (only_rx_req && ier_reg[`SIE_B_RX_DATA_REQ] && ier_reg[`SIE_B_RX_DMA_SEL])
        |=> (rx_dma_req && !irq_out))
        else $error("Receive request not steered to DMA alone");

    a_rx_cpu_route: assert property (
        (level_flags.rx_data_req && ier_reg[`SIE_B_RX_DATA_REQ] && !ier_reg[`SIE_B_RX_DMA_SEL])
        |=> (irq_out && !rx_dma_req))
        else $error("Receive request not steered to CPU");

    a_dma_req_gated: assert property (
        (!ier_reg[`SIE_B_TX_DATA_REQ] && !ier_reg[`SIE_B_RX_DATA_REQ])
        |=> (!tx_dma_req && !rx_dma_req))
        else $error("Transfer request issued while disabled");

    a_err_w1c_clear: assert property (
        (wr_stat && (err_evt_vec == `SIE_ERR_RESET))
        |=> ((err_reg & $past(bus.wdata[`SIE_B_ERR_HI:`SIE_B_ERR_LO])) == `SIE_ERR_RESET)
            && ((err_reg & ~$past(bus.wdata[`SIE_B_ERR_HI:`SIE_B_ERR_LO]))
                == ($past(err_reg) & ~$past(bus.wdata[`SIE_B_ERR_HI:`SIE_B_ERR_LO]))))
        else $error("Error flag write-one-clear misbehaved");

    a_err_set_wins: assert property (
        (|err_evt_vec) |=> ((err_reg & $past(err_evt_vec)) == $past(err_evt_vec)))
        else $error("Error event lost");

    a_reset_quiet: assert property (
        $past(reset) |-> ((ier_reg == `SIE_IER_RESET) && !irq_out && !tx_dma_req && !rx_dma_req))
        else $error("Block not quiet after reset");

    a_read_one_cycle: assert property (
        !bus.rd |=> (rd_data == `SIE_DATA_ZERO))
        else $error("Read data present without read strobe");

    // ------------------------------------------------------------------
    // Register view and steering checks
    // ------------------------------------------------------------------

    a_stat_tx_levels: assert property (
        rd_stat |=> (rd_data[`SIE_B_TX_CTRL_RDY:`SIE_B_TX_DATA_REQ] == $past({level_flags.tx_ctrl_ready,
                     level_flags.tx_fifo_empty, level_flags.tx_data_req})))
        else $error("Status read shows wrong transmit levels");

    a_stat_rx_levels: assert property (
        rd_stat |=> (rd_data[`SIE_B_RX_CTRL_RDY:`SIE_B_RX_DATA_REQ] == $past({level_flags.rx_ctrl_ready,
                     level_flags.rx_fifo_full, level_flags.rx_data_req})))
        else $error("Status read shows wrong receive levels");

    a_stat_err_bits: assert property (
        rd_stat
        |=> (rd_data[`SIE_B_ERR_HI:`SIE_B_ERR_LO] == $past(err_reg)))
        else $error("Status read shows wrong error flags");

    a_stat_rsvd_zero: assert property (
        rd_stat |=> (!rd_data[`SIE_B_TX_DMA_SEL] && !rd_data[`SIE_B_RX_DMA_SEL]
                     && (rd_data[`SIE_B_RSVD_HI:`SIE_B_RSVD_LO] == 2'h0)))
        else $error("Status read shows nonzero unused bits");

    a_ier_hold: assert property (
        !wr_ier
        |=> (ier_reg == $past(ier_reg)))
        else $error("Enable register changed without a write");

    a_unmapped_wr_ignored: assert property (
        (bus.wr && !sel_ier && !sel_stat)
        |=> (err_reg == ($past(err_reg) | $past(err_evt_vec))))
        else $error("Unmapped write touched error flags");

    a_unmapped_rd_zero: assert property (
        (bus.rd && !sel_ier && !sel_stat)
        |=> (rd_data == `SIE_DATA_ZERO))
        else $error("Unmapped read returned nonzero data");

    a_err_hold_idle: assert property (
        (!wr_stat && (err_evt_vec == `SIE_ERR_RESET))
        |=> (err_reg == $past(err_reg)))
        else $error("Error flags changed without event or write");

    a_err_zero_write: assert property (
        (wr_stat && (bus.wdata[`SIE_B_ERR_HI:`SIE_B_ERR_LO] == `SIE_ERR_RESET))
        |=> (err_reg == ($past(err_reg) | $past(err_evt_vec))))
        else $error("Writing zero changed error flags");

    a_tx_dma_needs_sel: assert property (
        !ier_reg[`SIE_B_TX_DMA_SEL]
        |=> !tx_dma_req)
        else $error("Transmit transfer request while routed to CPU");

    a_rx_dma_needs_sel: assert property (
        !ier_reg[`SIE_B_RX_DMA_SEL]
        |=> !rx_dma_req)
        else $error("Receive transfer request while routed to CPU");

    a_tx_dma_needs_flag: assert property (
        !level_flags.tx_data_req
        |=> !tx_dma_req)
        else $error("Transmit transfer request without its flag");

    a_rx_dma_needs_flag: assert property (
        !level_flags.rx_data_req
        |=> !rx_dma_req)
        else $error("Receive transfer request without its flag");

    a_tx_dma_raise: assert property (
        (level_flags.tx_data_req && ier_reg[`SIE_B_TX_DATA_REQ] && ier_reg[`SIE_B_TX_DMA_SEL])
        |=> tx_dma_req)
        else $error("Transmit transfer request missing");

    a_rx_dma_raise: assert property (
        (level_flags.rx_data_req && ier_reg[`SIE_B_RX_DATA_REQ] && ier_reg[`SIE_B_RX_DMA_SEL])
        |=> rx_dma_req)
        else $error("Receive transfer request missing");

    a_tx_sel_blocks_irq: assert property (
        (only_tx_req && ier_reg[`SIE_B_TX_DMA_SEL])
        |=> !irq_out)
        else $error("Transmit source routed to DMA reached the interrupt");

    a_rx_sel_blocks_irq: assert property (
        (only_rx_req && ier_reg[`SIE_B_RX_DMA_SEL])
        |=> !irq_out)
        else $error("Receive source routed to DMA reached the interrupt");

endmodule

// >>> sie_regs.svh
// Purpose: Register map, field positions and reset values of the serial interrupt enable block
// Assumes: Included by the package and by the design module
// Notes:   Definitions only
`ifndef SIE_REGS_SVH
`define SIE_REGS_SVH

// ------------------------------------------------------------------
// Bus geometry
// ------------------------------------------------------------------
`define SIE_ADDR_W          8
`define SIE_DATA_W          16
`define SIE_ERR_W           6

// ------------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------------
`define SIE_OFF_IER         8'h00
`define SIE_OFF_STAT        8'h04

// ------------------------------------------------------------------
// Bit positions, shared by enable and status views
// ------------------------------------------------------------------
`define SIE_B_TX_DMA_SEL    15
`define SIE_B_TX_CTRL_RDY   14
`define SIE_B_TX_FIFO_EMPTY 13
`define SIE_B_TX_DATA_REQ   12
`define SIE_B_RX_DMA_SEL    11
`define SIE_B_RX_CTRL_RDY   10
`define SIE_B_RX_FIFO_FULL  9
`define SIE_B_RX_DATA_REQ   8
`define SIE_B_RSVD_HI       7
`define SIE_B_RSVD_LO       6
`define SIE_B_ERR_HI        5
`define SIE_B_ERR_LO        0

// ------------------------------------------------------------------
// Masks and reset values
// ------------------------------------------------------------------
`define SIE_IER_WMASK       16'hFF3F
`define SIE_IER_RESET       16'h0000
`define SIE_ERR_RESET       6'h00
`define SIE_DATA_ZERO       16'h0000

`endif

// >>> sie_pkg.sv
// Purpose: Types of the serial interrupt enable block
// Assumes: sie_regs.svh gives the widths
// Notes:   Struct field order matches status bit order
`include "sie_regs.svh"

package sie_pkg;

    // Register port request
    typedef struct packed {
        logic [`SIE_ADDR_W-1:0] addr;
        logic [`SIE_DATA_W-1:0] wdata;
        logic                   wr;
        logic                   rd;
    } sie_bus_req_t;

    // Level flags from the serial engine, bits 14..12 and 10..8
    typedef struct packed {
        logic tx_ctrl_ready;
        logic tx_fifo_empty;
        logic tx_data_req;
        logic rx_ctrl_ready;
        logic rx_fifo_full;
        logic rx_data_req;
    } sie_level_t;

    // One-cycle error events, bits 5..0
    typedef struct packed {
        logic slot_assign;
        logic frame_sync;
        logic tx_overflow;
        logic tx_underflow;
        logic rx_underflow;
        logic rx_overflow;
    } sie_err_t;

endpackage

// >>> sie_dma_cpu_model.sv
// Purpose: CPU interrupt input and DMA request receiver facing the block
// Assumes: All request lines are levels on clk_sys
// Notes:   Counts assertions of each line, cleared by reset
`timescale 1ns/1ns
module sie_dma_cpu_model
(
    input  wire logic       clk_sys,   // System clock
    input  wire logic       reset,     // Asynchronous reset, active high
    input  wire logic       irq_out,   // CPU interrupt level
    input  wire logic       tx_req,    // Transmit DMA request
    input  wire logic       rx_req,    // Receive DMA request
    output logic [15:0]     irq_rises, // Interrupt assertions seen
    output logic [15:0]     tx_rises,  // Transmit requests seen
    output logic [15:0]     rx_rises   // Receive requests seen
);
    logic [2:0] prev_reg;

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            prev_reg  <= 3'h0;
            irq_rises <= 16'h0000;
            tx_rises  <= 16'h0000;
            rx_rises  <= 16'h0000;
        end
        else
        begin
            prev_reg  <= {irq_out, tx_req, rx_req};
            irq_rises <= irq_rises + {15'h0000, irq_out & ~prev_reg[2]};
            tx_rises  <= tx_rises + {15'h0000, tx_req & ~prev_reg[1]};
            rx_rises  <= rx_rises + {15'h0000, rx_req & ~prev_reg[0]};
        end
    end
endmodule

// >>> testbench.sv
// Purpose: Self-checking bench of the serial interrupt enable block
// Assumes: Outputs follow their cause one edge later
// Notes:   Register access through one-cycle strobes
`timescale 1ns/1ns
`include "sie_regs.svh"
module testbench;
    logic                  clk_sys = 1'h0;
    logic                  reset;
    sie_pkg::sie_bus_req_t bus_req;
    logic [15:0]           rd_data;
    sie_pkg::sie_level_t   level_flags;
    sie_pkg::sie_err_t     err_evt;
    logic                  irq_out, tx_dma_req, rx_dma_req;
    logic [15:0]           irq_rises, tx_rises, rx_rises;
    int                    err_total = 0;
    int                    total_checks = 0;
    int                    pos;
    logic [15:0] st_ena [7] = '{16'h9000, 16'h1000, 16'h8000, 16'h0900, 16'h0100, 16'h9900, 16'hD900};
    logic [5:0]  st_lvl [7] = '{6'h08, 6'h08, 6'h08, 6'h01, 6'h01, 6'h09, 6'h29};
    logic [2:0]  st_exp [7] = '{3'h2, 3'h4, 3'h0, 3'h1, 3'h4, 3'h3, 3'h7};

    always #2 clk_sys = ~clk_sys;

    sie_irq_enable sie_irq_enable_inst (.clk_sys(clk_sys), .reset(reset), .bus(bus_req), .rd_data(rd_data),
        .level_flags(level_flags), .err_evt(err_evt), .irq_out(irq_out), .tx_dma_req(tx_dma_req),
        .rx_dma_req(rx_dma_req));
    sie_dma_cpu_model sie_dma_cpu_model_inst (.clk_sys(clk_sys), .reset(reset), .irq_out(irq_out),
        .tx_req(tx_dma_req), .rx_req(rx_dma_req), .irq_rises(irq_rises), .tx_rises(tx_rises),
        .rx_rises(rx_rises));

    // ------------------------------------------------------------------
    // Access and compare tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        bus_req.addr  <= a;
        bus_req.wdata <= d;
        bus_req.wr    <= 1'h1;
        @(posedge clk_sys);
        bus_req.wr    <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string nm);
        @(posedge clk_sys);
        bus_req.addr <= a;
        bus_req.rd   <= 1'h1;
        @(posedge clk_sys);
        bus_req.rd   <= 1'h0;
        #1;
        chk(nm, exp, rd_data);
    endtask

    task automatic setl(input logic [5:0] v);
        @(posedge clk_sys);
        level_flags <= v;
    endtask

    task automatic pulse(input logic [5:0] v);
        @(posedge clk_sys);
        err_evt <= v;
        @(posedge clk_sys);
        err_evt <= 6'h00;
    endtask

    task automatic settle;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask

    task automatic chk_out(input string nm, input logic [2:0] exp);
        chk(nm, {13'h0000, exp}, {13'h0000, irq_out, tx_dma_req, rx_dma_req});
    endtask

    task automatic print_verdict;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial
    begin
        #400000;
        err_total++;
        print_verdict;
    end

    initial
    begin
        reset = 1'h1;
        bus_req = '0;
        level_flags = '0;
        err_evt = '0;
        repeat (5) @(posedge clk_sys);
        reset <= 1'h0;
        rd(`SIE_OFF_IER, 16'h0000, "enable reset");
        setl(6'h3F);
        settle;
        chk_out("outputs after reset", 3'h0);
        rd(`SIE_OFF_STAT, 16'h7700, "status levels");
        setl(6'h00);
        wr(`SIE_OFF_IER, 16'hFFFF);
        rd(`SIE_OFF_IER, 16'hFF3F, "enable all");
        wr(8'h08, 16'h0000);
        rd(8'h08, 16'h0000, "unmapped read");
        rd(`SIE_OFF_IER, 16'hFF3F, "enable after unmapped write");
        // Write then read with no gap between the strobes
        @(posedge clk_sys);
        bus_req <= '{addr: `SIE_OFF_IER, wdata: 16'hA51A, wr: 1'h1, rd: 1'h0};
        @(posedge clk_sys);
        bus_req <= '{addr: `SIE_OFF_IER, wdata: 16'h0000, wr: 1'h0, rd: 1'h1};
        @(posedge clk_sys);
        bus_req.rd <= 1'h0;
        #1;
        chk("enable back to back", 16'hA51A, rd_data);
        // One level enable at a time against all flags set
        for (int k = 0; k < 6; k++)
        begin
            pos = k + 8 + ((k > 2) ? 1 : 0);
            wr(`SIE_OFF_IER, 16'h0001 << pos);
            setl(6'h3F);
            settle;
            chk("irq gate on", 16'h0001, {15'h0000, irq_out});
            setl(6'h3F ^ (6'h01 << k));
            settle;
            chk("irq gate off", 16'h0000, {15'h0000, irq_out});
        end
        setl(6'h00);
        // Sticky errors: masked, then enabled, then acknowledged
        for (int e = 0; e < 6; e++)
        begin
            wr(`SIE_OFF_IER, 16'hFF3F ^ (16'h0001 << e));
            pulse(6'h01 << e);
            settle;
            chk("irq masked error", 16'h0000, {15'h0000, irq_out});
            rd(`SIE_OFF_STAT, 16'h0001 << e, "error flag set");
            wr(`SIE_OFF_IER, 16'h0001 << e);
            settle;
            chk("irq error", 16'h0001, {15'h0000, irq_out});
            wr(`SIE_OFF_STAT, 16'h0000);
            settle;
            chk("irq after write zero", 16'h0001, {15'h0000, irq_out});
            wr(`SIE_OFF_STAT, 16'h0001 << e);
            settle;
            chk("irq after clear", 16'h0000, {15'h0000, irq_out});
            rd(`SIE_OFF_STAT, 16'h0000, "error flag cleared");
        end
        wr(`SIE_OFF_IER, 16'hFFFF);
        @(posedge clk_sys);
        reset <= 1'h1;
        @(posedge clk_sys);
        reset <= 1'h0;
        rd(`SIE_OFF_IER, 16'h0000, "enable after second reset");
        // Steering of data requests between CPU and DMA
        for (int r = 0; r < 7; r++)
        begin
            setl(6'h00);
            wr(`SIE_OFF_IER, st_ena[r]);
            setl(st_lvl[r]);
            settle;
            chk_out("steered outputs", st_exp[r]);
        end
        chk("cpu interrupt count", 16'h0003, irq_rises);
        chk("tx dma count", 16'h0003, tx_rises);
        chk("rx dma count", 16'h0003, rx_rises);
        print_verdict;
    end
endmodule
